// *** verilog/phy_lane_pkg.sv ***
//==============================================================================
// Constants, types and helpers shared by the lane partner controller.
// Assumes one 250 MHz core clock and an asynchronous active-low reset.
//==============================================================================
package phy_lane_pkg;

  //============================================================================
  // Widths.
  //============================================================================
  localparam int LANE_COUNT = 4;                 // Lanes of the link.
  localparam int BYTES      = 4 * LANE_COUNT;    // Bytes per link word.
  localparam int DATA_W     = 32 * LANE_COUNT;   // Link word width.
  localparam int ADDR_W     = 8;                 // Register address width.
  localparam int FREE_W     = 6;                 // Free-count bus width.
  localparam int RAW_W      = 16;                // Raw free-count width.

  //============================================================================
  // Register offsets and field positions.
  //============================================================================
  localparam logic [ADDR_W-1:0] CTRL_OFS   = 8'h00;  // Control bits.
  localparam logic [ADDR_W-1:0] FREE_OFS   = 8'h04;  // Raw free locations.
  localparam logic [ADDR_W-1:0] INJECT_OFS = 8'h08;  // One-shot error injection.
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h0C;  // Lane status.
  localparam logic [ADDR_W-1:0] TXCAP_OFS  = 8'h10;  // Captured lane words, one per lane.
  localparam int CTRL_LOOP_BIT   = 0;                // Loop transmit words back.
  localparam int CTRL_FLOW_BIT   = 1;                // Transmitter-controlled flow mode.
  localparam int CTRL_RSTREQ_BIT = 2;                // Ask the device for a reset.

  //============================================================================
  // Reset values and codes.
  //============================================================================
  localparam logic CTRL_LOOP_RESET = 1'b1;           // Loopback on after reset.
  localparam logic CTRL_FLOW_RESET = 1'b0;           // Receiver flow mode after reset.
  localparam logic [RAW_W-1:0] FREE_RAW_RESET = 16'h0000;
  localparam logic [FREE_W-1:0] FREE_SAT = 6'h1E;    // Saturation value, thirty.
  localparam logic [7:0] COMMA_CODE = 8'hBC;         // Comma control character.
  localparam logic [7:0] BOND_CODE  = 8'h7C;         // Bonding sequence marker.

  //============================================================================
  // Timing.
  //============================================================================
  localparam int CLK_MHZ         = 250;
  localparam int RESET_SETTLE_NS = 100;              // Least time from reset release to done.
  localparam int RESET_SETTLE_CYCLES = (RESET_SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int SETTLE_W = 5;
  localparam logic [SETTLE_W-1:0] SETTLE_LAST = SETTLE_W'(RESET_SETTLE_CYCLES - 1);

  // Reset handshake states.
  typedef enum logic [1:0] {
    RS_IDLE   = 2'b00,
    RS_REQ    = 2'b01,
    RS_HELD   = 2'b10,
    RS_SETTLE = 2'b11
  } rst_state_e;

  // Byte idx of a link word.
  function automatic logic [7:0] get_byte(input logic [DATA_W-1:0] w, input int idx);
    get_byte = w[idx*8 +: 8];
  endfunction

  // Clamp a raw count so the bus can never look like receiver flow control.
  function automatic logic [FREE_W-1:0] saturate_free(input logic [RAW_W-1:0] raw);
    if (raw > RAW_W'(FREE_SAT)) begin
      saturate_free = FREE_SAT;
    end else begin
      saturate_free = raw[FREE_W-1:0];
    end
  endfunction

endpackage

// *** verilog/lane_word_if.sv ***
//==============================================================================
// Received link word with its per-byte and per-lane flags.
// Assumes both ends run on the core clock.
//==============================================================================
`timescale 1ns/100ps
interface lane_word_if;
  import phy_lane_pkg::*;
  logic [DATA_W-1:0]     data;      // Received bytes.
  logic [BYTES-1:0]      ctrl;      // Control-character flags.
  logic [BYTES-1:0]      comma;     // Comma flags.
  logic [BYTES-1:0]      disp_err;  // Disparity error flags.
  logic [BYTES-1:0]      code_err;  // Decode error flags.
  logic [LANE_COUNT-1:0] bond_seq;  // Bonding sequence seen.
  modport former (output data, ctrl, comma, disp_err, code_err, bond_seq);
  modport user   (input  data, ctrl, comma, disp_err, code_err, bond_seq);
endinterface

// *** verilog/free_count_encoder.sv ***
//==============================================================================
// Registered free-count encoder for the receive-buffer status bus.
// Assumes the raw count comes from a software register.
//==============================================================================
`timescale 1ns/100ps
module free_count_encoder
  import phy_lane_pkg::*;
(
  // Clock and reset.
  input  wire logic              clk_in,
  input  wire logic              arst_n_in,
  // Raw count and encoded bus.
  input  wire logic [RAW_W-1:0]  raw_in,
  output logic      [FREE_W-1:0] free_out
);
  // All state of the encoder.
  typedef struct packed {
    logic [FREE_W-1:0] free;
  } enc_state_s;

  enc_state_s st_reg;   // Registered state.
  enc_state_s st_next;  // Next state.

  // Saturation keeps the value at most thirty, so neither all ones nor five low ones appear.
  always_comb begin
    st_next      = st_reg;
    st_next.free = saturate_free(raw_in);
  end

  // State register.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign free_out = st_reg.free;
endmodule

// *** verilog/rx_flag_former.sv ***
//==============================================================================
// Forms the received link word and all its flags from the transmitted word.
// Assumes lane status and masks arrive registered from the controller.
//==============================================================================
`timescale 1ns/100ps
module rx_flag_former
  import phy_lane_pkg::*;
(
  // Clock and reset.
  input  wire logic                  clk_in,
  input  wire logic                  arst_n_in,
  // Transmit side of the device.
  input  wire logic [DATA_W-1:0]     tx_data_in,
  input  wire logic [BYTES-1:0]      tx_ctrl_in,
  input  wire logic [LANE_COUNT-1:0] tx_inhibit_in,
  // Controls.
  input  wire logic                  loop_en_in,
  input  wire logic                  bond_en_in,
  input  wire logic [LANE_COUNT-1:0] lane_up_in,
  input  wire logic [BYTES-1:0]      disp_inj_in,
  input  wire logic [BYTES-1:0]      code_inj_in,
  // Received word.
  lane_word_if.former                rx
);
  // All state of the former.
  typedef struct packed {
    logic [DATA_W-1:0]     data;
    logic [BYTES-1:0]      ctrl;
    logic [BYTES-1:0]      comma;
    logic [BYTES-1:0]      disp_err;
    logic [BYTES-1:0]      code_err;
    logic [LANE_COUNT-1:0] bond_seq;
  } rx_state_s;

  rx_state_s st_reg;   // Registered state.
  rx_state_s st_next;  // Next state.

  // Out of reset every lane reads as undecodable, so no clean word slips out before done.
  localparam rx_state_s RX_RESET = '{data: '0, ctrl: '0, comma: '0, disp_err: '0, code_err: '1, bond_seq: '0};

  // Each byte is either a looped transmit byte, an idle comma, or dead air.
  always_comb begin
    int l;
    l       = 0;
    st_next = st_reg;
    for (int b = 0; b < BYTES; b++) begin
      l = b / 4;
      if (!lane_up_in[l]) begin
        // A lane still in reset delivers nothing decodable.
        st_next.data[b*8 +: 8] = 8'h00;
        st_next.ctrl[b]        = 1'b0;
        st_next.code_err[b]    = 1'b1;
      end else if (tx_inhibit_in[l]) begin
        // An inhibited transmitter leaves the line silent, so decoding fails.
        st_next.data[b*8 +: 8] = 8'h00;
        st_next.ctrl[b]        = 1'b0;
        st_next.code_err[b]    = 1'b1;
      end else if (loop_en_in) begin
        st_next.data[b*8 +: 8] = get_byte(tx_data_in, b);
        st_next.ctrl[b]        = tx_ctrl_in[b];
        st_next.code_err[b]    = code_inj_in[b];
      end else begin
        // Idle: a comma in the first byte of each lane, zero elsewhere.
        st_next.data[b*8 +: 8] = (b % 4 == 0) ? COMMA_CODE : 8'h00;
        st_next.ctrl[b]        = (b % 4 == 0);
        st_next.code_err[b]    = code_inj_in[b];
      end
      st_next.disp_err[b] = lane_up_in[l] & disp_inj_in[b];
      st_next.comma[b] = st_next.ctrl[b] && (st_next.data[b*8 +: 8] == COMMA_CODE);
    end
    for (int n = 0; n < LANE_COUNT; n++) begin
      // A bonding marker in byte 0 counts only while bonding is enabled.
      st_next.bond_seq[n] = bond_en_in && st_next.ctrl[4*n] &&
                            (st_next.data[32*n +: 8] == BOND_CODE);
    end
  end

  // State register.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_reg <= RX_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rx.data     = st_reg.data;
  assign rx.ctrl     = st_reg.ctrl;
  assign rx.comma    = st_reg.comma;
  assign rx.disp_err = st_reg.disp_err;
  assign rx.code_err = st_reg.code_err;
  assign rx.bond_seq = st_reg.bond_seq;
endmodule

// *** verilog/lane_partner_host.sv ***
//==============================================================================
// Lane partner controller: plays the transceivers and the packet buffer
// on the lane-side pins of the physical layer port.
// Assumes all device pins are synchronous to CORE_CLK_IN, and that software
// reaches the control registers over a plain strobe port.
//==============================================================================
`timescale 1ns/100ps
module lane_partner_host
  import phy_lane_pkg::*;
(
  // Clock and reset.
  input  wire logic                  CORE_CLK_IN,
  input  wire logic                  ARST_N_IN,
  // Software register port.
  input  wire logic [ADDR_W-1:0]     REG_ADDR_IN,
  input  wire logic [31:0]           REG_WDATA_IN,
  input  wire logic                  REG_WR_IN,
  input  wire logic                  REG_RD_IN,
  output logic      [31:0]           REG_RDATA_OUT,
  // Transmit pins from the device.
  input  wire logic [DATA_W-1:0]     TX_DATA_IN,
  input  wire logic [BYTES-1:0]      TX_CTRL_IN,
  input  wire logic [LANE_COUNT-1:0] TX_INHIBIT_IN,
  // Receive pins to the device.
  output logic      [DATA_W-1:0]     RX_DATA_OUT,
  output logic      [BYTES-1:0]      RX_CTRL_OUT,
  output logic      [BYTES-1:0]      RX_COMMA_OUT,
  output logic      [BYTES-1:0]      RX_DISP_ERR_OUT,
  output logic      [BYTES-1:0]      RX_CODE_ERR_OUT,
  // Channel bonding.
  input  wire logic                  BOND_EN_IN,
  output logic      [LANE_COUNT-1:0] BOND_SEQ_OUT,
  output logic      [LANE_COUNT-1:0] BOND_ALIGNED_OUT,
  // Transceiver reset handshake.
  output logic                       XCVR_RESET_REQ_OUT,
  input  wire logic                  XCVR_RESET_IN,
  output logic      [LANE_COUNT-1:0] RESET_DONE_OUT,
  // Packet buffer status.
  output logic      [FREE_W-1:0]     FREE_COUNT_OUT,
  output logic                       TX_FLOW_CTRL_OUT
);

  //============================================================================
  // State.
  //============================================================================
  // All state of the controller in one record.
  typedef struct packed {
    logic                  loop_en;     // Loop transmit words back.
    logic                  flow_mode;   // Transmitter-controlled flow mode.
    logic                  rst_req;     // Software reset request pending.
    logic [RAW_W-1:0]      free_raw;    // Raw free locations from software.
    logic [BYTES-1:0]      disp_inj;    // One-shot disparity error injection.
    logic [BYTES-1:0]      code_inj;    // One-shot decode error injection.
    logic [31:0]           rdata;       // Read data, one cycle after the strobe.
    rst_state_e            rst_state;   // Reset handshake state.
    logic [SETTLE_W-1:0]   settle_cnt;  // Cycles since reset release.
    logic [LANE_COUNT-1:0] done;        // Per-lane reset completion.
    logic [LANE_COUNT-1:0] aligned;     // Per-lane alignment.
    logic [DATA_W-1:0]     tx_cap;      // Last word seen on each lane whose transmitter is not inhibited.
  } host_state_s;

  // Power-up starts in the settle phase, so lanes report done only later.
  localparam host_state_s HOST_RESET = '{
    loop_en:    CTRL_LOOP_RESET,
    flow_mode:  CTRL_FLOW_RESET,
    rst_req:    1'b0,
    free_raw:   FREE_RAW_RESET,
    disp_inj:   '0,
    code_inj:   '0,
    rdata:      32'h0000_0000,
    rst_state:  RS_SETTLE,
    settle_cnt: '0,
    done:       '0,
    aligned:    '0,
    tx_cap:     '0
  };

  host_state_s st_reg;   // Registered state.
  host_state_s st_next;  // Next state.

  lane_word_if rx ();    // Received word from the former.

  //============================================================================
  // Sub-blocks.
  //============================================================================
  // Builds the receive word and flags; its outputs are flip-flops.
  rx_flag_former u_former (
    .clk_in        (CORE_CLK_IN),
    .arst_n_in     (ARST_N_IN),
    .tx_data_in    (TX_DATA_IN),
    .tx_ctrl_in    (TX_CTRL_IN),
    .tx_inhibit_in (TX_INHIBIT_IN),
    .loop_en_in    (st_reg.loop_en),
    .bond_en_in    (BOND_EN_IN),
    .lane_up_in    (st_reg.done),
    .disp_inj_in   (st_reg.disp_inj),
    .code_inj_in   (st_reg.code_inj),
    .rx            (rx.former)
  );

  // Clamps the software count before it reaches the device.
  free_count_encoder u_free (
    .clk_in    (CORE_CLK_IN),
    .arst_n_in (ARST_N_IN),
    .raw_in    (st_reg.free_raw),
    .free_out  (FREE_COUNT_OUT)
  );

  //============================================================================
  // Next-state logic.
  //============================================================================
  // Register writes, reads, reset handshake, alignment and capture.
  always_comb begin
    logic wr_ctrl;
    logic [7:0] lane_sel;
    wr_ctrl  = REG_WR_IN && (REG_ADDR_IN == CTRL_OFS);
    lane_sel = 8'h00;
    st_next  = st_reg;

    // Injections last exactly one cycle, so each write hits one word.
    st_next.disp_inj = '0;
    st_next.code_inj = '0;

    // Software writes.
    if (REG_WR_IN) begin
      case (REG_ADDR_IN)
        CTRL_OFS: begin
          st_next.loop_en   = REG_WDATA_IN[CTRL_LOOP_BIT];
          st_next.flow_mode = REG_WDATA_IN[CTRL_FLOW_BIT];
        end
        FREE_OFS: begin
          st_next.free_raw = REG_WDATA_IN[RAW_W-1:0];
        end
        INJECT_OFS: begin
          st_next.disp_inj = REG_WDATA_IN[BYTES-1:0];
          st_next.code_inj = REG_WDATA_IN[2*BYTES-1:BYTES];
        end
        default: begin
          // Read-only and unmapped offsets ignore writes.
        end
      endcase
    end

    // Reset handshake with the device.
    case (st_reg.rst_state)
      RS_IDLE: begin
        if (XCVR_RESET_IN) begin
          st_next.rst_state = RS_HELD;
        end else if (st_reg.rst_req) begin
          st_next.rst_state = RS_REQ;
        end
      end
      RS_REQ: begin
        if (XCVR_RESET_IN) begin
          st_next.rst_state = RS_HELD;
        end
      end
      RS_HELD: begin
        // Lanes drop done on the first edge in this state, a cycle after the device reset is seen.
        st_next.done       = '0;
        st_next.settle_cnt = '0;
        if (!XCVR_RESET_IN) begin
          st_next.rst_state = RS_SETTLE;
        end
      end
      RS_SETTLE: begin
        if (XCVR_RESET_IN) begin
          st_next.rst_state = RS_HELD;
        end else if (st_reg.settle_cnt == SETTLE_LAST) begin
          st_next.done      = '1;
          st_next.rst_state = RS_IDLE;
        end else begin
          st_next.settle_cnt = st_reg.settle_cnt + SETTLE_W'(1);
        end
      end
      default: begin
        st_next.rst_state = RS_HELD;
      end
    endcase

    // The request clears once the device answers; a new software set wins.
    if (st_reg.rst_state == RS_HELD) begin
      st_next.rst_req = 1'b0;
    end
    if (wr_ctrl && REG_WDATA_IN[CTRL_RSTREQ_BIT]) begin
      st_next.rst_req = 1'b1;
    end

    // Alignment holds from a bonding marker until bonding or the lane stops.
    for (int n = 0; n < LANE_COUNT; n++) begin
      if (!BOND_EN_IN || !st_reg.done[n]) begin
        st_next.aligned[n] = 1'b0;
      end else if (rx.bond_seq[n]) begin
        st_next.aligned[n] = 1'b1;
      end
      if (!TX_INHIBIT_IN[n]) begin
        st_next.tx_cap[32*n +: 32] = TX_DATA_IN[32*n +: 32];
      end
    end

    // Read data stand in the cycle after the strobe only.
    st_next.rdata = 32'h0000_0000;
    if (REG_RD_IN) begin
      case (REG_ADDR_IN)
        CTRL_OFS: begin
          st_next.rdata = {29'h0000_0000, st_reg.rst_req, st_reg.flow_mode, st_reg.loop_en};
        end
        FREE_OFS: begin
          st_next.rdata = {16'h0000, st_reg.free_raw};
        end
        INJECT_OFS: begin
          st_next.rdata = {st_reg.code_inj, st_reg.disp_inj};
        end
        STATUS_OFS: begin
          st_next.rdata = {17'h0_0000, st_reg.rst_req, XCVR_RESET_IN, BOND_EN_IN,
                           TX_INHIBIT_IN, st_reg.aligned, st_reg.done};
        end
        default: begin
          // Captured lane words sit one per word above their base.
          if (REG_ADDR_IN >= TXCAP_OFS && REG_ADDR_IN < TXCAP_OFS + 8'(4 * LANE_COUNT) &&
              REG_ADDR_IN[1:0] == 2'b00) begin
            lane_sel      = (REG_ADDR_IN - TXCAP_OFS) >> 2;
            st_next.rdata = st_reg.tx_cap[32*lane_sel[1:0] +: 32];
          end
        end
      endcase
    end
  end

  //============================================================================
  // State register.
  //============================================================================
  // One register for the whole record keeps reset values in one place.
  always_ff @(posedge CORE_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      st_reg <= HOST_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  //============================================================================
  // Outputs.
  //============================================================================
  assign REG_RDATA_OUT      = st_reg.rdata;
  assign RX_DATA_OUT        = rx.data;
  assign RX_CTRL_OUT        = rx.ctrl;
  assign RX_COMMA_OUT       = rx.comma;
  assign RX_DISP_ERR_OUT    = rx.disp_err;
  assign RX_CODE_ERR_OUT    = rx.code_err;
  assign BOND_SEQ_OUT       = rx.bond_seq;
  assign BOND_ALIGNED_OUT   = st_reg.aligned;
  assign XCVR_RESET_REQ_OUT = (st_reg.rst_state == RS_REQ);
  assign RESET_DONE_OUT     = st_reg.done;
  assign TX_FLOW_CTRL_OUT   = st_reg.flow_mode;
endmodule

// *** bench/lane_host_chk.sv ***
// Port checker for the lane partner controller.
// Assumes it is bound to lane_partner_host and sees only its ports.
`timescale 1ns/100ps
module lane_host_chk
  import phy_lane_pkg::*;
(
  input wire logic                  CORE_CLK_IN,
  input wire logic                  ARST_N_IN,
  input wire logic [ADDR_W-1:0]     REG_ADDR_IN,
  input wire logic [31:0]           REG_WDATA_IN,
  input wire logic                  REG_WR_IN,
  input wire logic                  REG_RD_IN,
  input wire logic [31:0]           REG_RDATA_OUT,
  input wire logic [DATA_W-1:0]     RX_DATA_OUT,
  input wire logic [BYTES-1:0]      RX_CODE_ERR_OUT,
  input wire logic                  BOND_EN_IN,
  input wire logic [LANE_COUNT-1:0] BOND_ALIGNED_OUT,
  input wire logic                  XCVR_RESET_REQ_OUT,
  input wire logic                  XCVR_RESET_IN,
  input wire logic [LANE_COUNT-1:0] RESET_DONE_OUT,
  input wire logic [FREE_W-1:0]     FREE_COUNT_OUT,
  input wire logic                  TX_FLOW_CTRL_OUT
);
  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (!ARST_N_IN);
  logic [FREE_W-1:0] exp_free;  // Clamped write data, kept one cycle.
  // Expected values are kept because the outputs lag the write by two edges.
  always_ff @(posedge CORE_CLK_IN) begin
    exp_free <= (REG_WDATA_IN[15:0] > 16'h001E) ? 6'h1E : REG_WDATA_IN[5:0];
  end
  chk_free_ones: assert property (FREE_COUNT_OUT != 6'h3F)
    else $error("free count shows all ones");
  chk_free_low: assert property (FREE_COUNT_OUT[4:0] != 5'h1F)
    else $error("free count low bits all ones");
  chk_free_sat: assert property ((REG_WR_IN && REG_ADDR_IN == FREE_OFS) |=> ##1 FREE_COUNT_OUT == $past(exp_free))
    else $error("free count not clamped write value");
  chk_flow_mode: assert property ((REG_WR_IN && REG_ADDR_IN == CTRL_OFS)
    |=> TX_FLOW_CTRL_OUT == $past(REG_WDATA_IN[CTRL_FLOW_BIT]))
    else $error("flow flag does not follow mode");
  chk_req_rise: assert property ((REG_WR_IN && REG_ADDR_IN == CTRL_OFS && REG_WDATA_IN[CTRL_RSTREQ_BIT]
    && !XCVR_RESET_IN) |=> ##1 XCVR_RESET_REQ_OUT)
    else $error("reset request not raised");
  chk_req_drop: assert property ((XCVR_RESET_IN && !REG_WR_IN && !$past(REG_WR_IN)) |=> !XCVR_RESET_REQ_OUT)
    else $error("reset request held during reset");
  chk_done_drop: assert property (XCVR_RESET_IN |=> ##1 RESET_DONE_OUT == 4'h0)
    else $error("done stays up in reset");
  chk_done_back: assert property ($fell(XCVR_RESET_IN) |-> (RESET_DONE_OUT == 4'h0) [*8] ##[14:20] RESET_DONE_OUT == 4'hF)
    else $error("done settle time wrong");
  chk_dead_lanes: assert property ((RESET_DONE_OUT == 4'h0 && $past(RESET_DONE_OUT) == 4'h0)
    |-> (RX_CODE_ERR_OUT == 16'hFFFF && RX_DATA_OUT == '0))
    else $error("data passed from lanes in reset");
  chk_bond_off: assert property (!BOND_EN_IN |=> BOND_ALIGNED_OUT == 4'h0)
    else $error("aligned without bonding enable");
  chk_rd_quiet: assert property (!$past(REG_RD_IN) |-> REG_RDATA_OUT == 32'h0000_0000)
    else $error("read data outside read slot");
  cover property (XCVR_RESET_REQ_OUT);
  cover property (BOND_ALIGNED_OUT == 4'hF);
  cover property (FREE_COUNT_OUT == 6'h1E);
endmodule
bind lane_partner_host lane_host_chk chk (.*);

// *** bench/dev_model.sv ***
// Model of the documented port: answers reset requests after a delay.
// Assumes the bench drives the transmit pins itself.
`timescale 1ns/100ps
module dev_model
  import phy_lane_pkg::*;
(
  // Clock and reset.
  input  wire logic       clk_in,
  input  wire logic       arst_n_in,
  // Reset handshake.
  input  wire logic       req_in,    // Request from the transceivers.
  input  wire logic [3:0] dly_in,    // Extra wait before answering, at most 11.
  output logic            xrst_out   // Transceiver reset, held four cycles.
);
  logic [3:0] cnt_reg;  // Cycles left in the answer.
  // A request is answered once; the request drops while the reset is high.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt_reg  <= 4'h0;
      xrst_out <= 1'b0;
    end else if (cnt_reg != 4'h0) begin
      cnt_reg  <= cnt_reg - 4'h1;
      xrst_out <= (cnt_reg <= 4'h4);
    end else begin
      cnt_reg  <= (req_in && !xrst_out) ? dly_in + 4'h4 : 4'h0;
      xrst_out <= 1'b0;
    end
  end
endmodule

// *** bench/tb.sv ***
// Self-checking bench for the lane partner controller.
// Assumes dev_model answers reset requests and the checker is bound.
`timescale 1ns/100ps
module tb;
  import phy_lane_pkg::*;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, bond = 0, req, xrst, flow;
  logic [ADDR_W-1:0]     addr = '0;
  logic [31:0]           wdata = '0, rdata;
  logic [DATA_W-1:0]     txd = '0, rxd;
  logic [BYTES-1:0]      txk = '0, rxk, rxc, rxp, rxn;
  logic [LANE_COUNT-1:0] inh = '0, seq, alg, done;
  logic [FREE_W-1:0]     free;
  logic [3:0]            dly = 4'h0;
  int num_errors = 0, comparisons = 0;
  localparam logic [127:0] W = 128'h0F0E_0D0C_0B0A_0908_0706_0504_0302_01BC;
  always #2 clk = ~clk;
  lane_partner_host dut (.CORE_CLK_IN(clk), .ARST_N_IN(rst_n), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
    .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata), .TX_DATA_IN(txd), .TX_CTRL_IN(txk),
    .TX_INHIBIT_IN(inh), .RX_DATA_OUT(rxd), .RX_CTRL_OUT(rxk), .RX_COMMA_OUT(rxc), .RX_DISP_ERR_OUT(rxp),
    .RX_CODE_ERR_OUT(rxn), .BOND_EN_IN(bond), .BOND_SEQ_OUT(seq), .BOND_ALIGNED_OUT(alg),
    .XCVR_RESET_REQ_OUT(req), .XCVR_RESET_IN(xrst), .RESET_DONE_OUT(done), .FREE_COUNT_OUT(free),
    .TX_FLOW_CTRL_OUT(flow));
  dev_model model (.clk_in(clk), .arst_n_in(rst_n), .req_in(req), .dly_in(dly), .xrst_out(xrst));
  task automatic wrap_up();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(string what, logic [127:0] exp, logic [127:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr_reg(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask
  task automatic rd_chk(logic [7:0] a, logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 chk("rdata", e, rdata);
  endtask
  // Transmit pins belong to the device side; lane n sits at [32n+:32].
  task automatic send(logic [127:0] d, logic [15:0] k, logic [3:0] i);
    @(posedge clk);
    txd <= d;
    txk <= k;
    inh <= i;
    @(posedge clk);
    #1;
  endtask
  task automatic wait_done(logic [3:0] want);
    for (int i = 0; i < 200 && done !== want; i++) @(posedge clk) #1;
    if (done !== want) begin
      num_errors++;
      wrap_up();
    end
  endtask
  task automatic t_regs();
    rd_chk(CTRL_OFS, 32'h0000_0001);
    rd_chk(FREE_OFS, 32'h0000_0000);
    wr_reg(STATUS_OFS, 32'hFFFF_FFFF);
    rd_chk(STATUS_OFS, 32'h0000_000F);
    rd_chk(8'h40, 32'h0000_0000);
  endtask
  task automatic t_words();
    send(W, 16'h0001, 4'h0);
    chk("rxd", W, rxd);
    chk("rxk", 16'h0001, rxk);
    chk("rxc", 16'h0001, rxc);
    send(W, 16'h0001, 4'h2);
    chk("rxd", W & ~(128'hFFFF_FFFF << 32), rxd);
    chk("rxn", 16'h00F0, rxn);
    send(W, 16'h0001, 4'h0);
    wr_reg(INJECT_OFS, 32'h0020_0001);
    @(posedge clk) #1 chk("rxp", 16'h0001, rxp);
    chk("rxn", 16'h0020, rxn);
    chk("valid", 16'hFFDE, 16'(~(rxp | rxn)));
    @(posedge clk) #1 chk("rxp", 16'h0000, rxp);
    wr_reg(CTRL_OFS, 32'h0000_0000);
    send(W, 16'h0001, 4'h0);
    chk("idle", {4{32'h0000_00BC}}, rxd);
    chk("rxc", 16'h1111, rxc);
    rd_chk(TXCAP_OFS + 8'h04, 32'h0706_0504);
  endtask
  task automatic t_status();
    logic [15:0] raw[5] = '{16'h001F, 16'h001E, 16'h0011, 16'hFFFF, 16'h003F};
    for (int i = 0; i < 5; i++) begin
      wr_reg(FREE_OFS, {16'h0000, raw[i]});
      @(posedge clk) #1 chk("free", (raw[i] > 16'h001E) ? 6'h1E : raw[i][5:0], free);
      wr_reg(CTRL_OFS, {30'h0, i[0], 1'b1});
      @(posedge clk) #1 chk("flow", i[0], flow);
    end
  endtask
  task automatic t_bond();
    @(posedge clk) bond <= 1'b1;
    send({4{32'h0000_007C}}, 16'h1111, 4'h0);
    chk("seq", 4'hF, seq);
    @(posedge clk) #1 chk("aligned", 4'hF, alg);
    @(posedge clk) bond <= 1'b0;
    @(posedge clk) #1 chk("aligned", 4'h0, alg);
  endtask
  task automatic t_reset(logic [3:0] d);
    dly <= d;
    wr_reg(CTRL_OFS, 32'h0000_0005);
    @(posedge clk) #1 chk("req", 1'b1, req);
    wait_done(4'h0);
    send(W, 16'h0001, 4'h0);
    chk("rxn", 16'hFFFF, rxn);
    wait_done(4'hF);
    chk("req", 1'b0, req);
    rd_chk(STATUS_OFS, 32'h0000_000F);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    wait_done(4'hF);
    t_regs();
    t_words();
    t_status();
    t_bond();
    t_reset(4'h0);
    t_reset(4'h9);
    wrap_up();
  end
endmodule
